/* File: common/fsr_pkg.sv */
// Package with constants and types for the fault state and ADC result registers
package fsr_pkg;

	// Register indices on the register port
	localparam logic [3:0] FSR_IDX_CFG = 4'h0;
	localparam logic [3:0] FSR_IDX_RESULT = 4'h1;

	// Reset values
	localparam logic [15:0] FSR_CFG_RESET = 16'h0000;
	localparam logic [15:0] FSR_RESULT_RESET = 16'h0000;
	localparam logic [5:0] FSR_STAMP_RESET = 6'h00;

	// Configuration field positions (lsb of each 2-bit field)
	localparam int FSR_POS_UV_POS = 14;
	localparam int FSR_POS_OV_POS = 12;
	localparam int FSR_POS_UV_NEG = 10;
	localparam int FSR_POS_OV_NEG = 8;
	localparam int FSR_POS_TRIM = 6;
	localparam int FSR_POS_CFGCHK = 4;
	localparam int FSR_POS_CLAMP = 2;
	localparam int FSR_POS_CLKMON = 0;

	// Result field positions
	localparam int FSR_POS_CODE = 0;
	localparam int FSR_POS_STAMP = 10;
	localparam int FSR_CODE_W = 10;
	localparam int FSR_STAMP_W = 6;

	// Number of fault sources with an output-state field
	localparam int FSR_NFAULT = 7;

	// Output-state codes
	localparam logic [1:0] FSR_ACT_LOW = 2'h0;
	localparam logic [1:0] FSR_ACT_HIGH = 2'h1;
	localparam logic [1:0] FSR_ACT_RSVD = 2'h2;
	localparam logic [1:0] FSR_ACT_NONE = 2'h3;

	// Clamp hold timing: one code step is 100 ns
	localparam int FSR_CLK_PERIOD_PS = 5000;
	localparam int FSR_CLAMP_STEP_NS = 100;
	localparam int FSR_CLAMP_STEP_CYC =
		(FSR_CLAMP_STEP_NS * 1000 + FSR_CLK_PERIOD_PS - 1) / FSR_CLK_PERIOD_PS;
	localparam int FSR_CLAMP_CNT_W = 7;

	// Fault sources, bit order matches fsr_fault_lsb
	typedef struct packed {
		logic clock_watch;
		logic config_check;
		logic trim_check;
		logic neg_overvolt;
		logic neg_undervolt;
		logic pos_overvolt;
		logic pos_undervolt;
	} fsr_fault_s;

	// Configuration register layout
	typedef struct packed {
		logic [1:0] pos_supply_undervolt_out_state;
		logic [1:0] pos_supply_overvolt_out_state;
		logic [1:0] neg_supply_undervolt_out_state;
		logic [1:0] neg_supply_overvolt_out_state;
		logic [1:0] trim_check_fail_out_state;
		logic [1:0] config_check_fail_out_state;
		logic [1:0] collector_clamp_hold_time;
		logic [1:0] clock_watch_fail_out_state;
	} fsr_cfg_s;

	// Result register layout
	typedef struct packed {
		logic [5:0] time_stamp;
		logic [9:0] analog_one_code;
	} fsr_result_s;

	typedef enum logic [1:0] {
		FSR_CLAMP_IDLE = 2'b01,
		FSR_CLAMP_HOLD = 2'b10
	} fsr_clamp_e;

	// Field lsb of fault source i in the configuration word
	function automatic int fsr_fault_lsb(input int i);
		case (i)
			0: fsr_fault_lsb = FSR_POS_UV_POS;
			1: fsr_fault_lsb = FSR_POS_OV_POS;
			2: fsr_fault_lsb = FSR_POS_UV_NEG;
			3: fsr_fault_lsb = FSR_POS_OV_NEG;
			4: fsr_fault_lsb = FSR_POS_TRIM;
			5: fsr_fault_lsb = FSR_POS_CFGCHK;
			default: fsr_fault_lsb = FSR_POS_CLKMON;
		endcase
	endfunction

endpackage

/* File: verilog/fsr_fault_action.sv */
// Combines active fault sources into a forced gate state
`timescale 1ns/1ps
`default_nettype none
module fsr_fault_action
	import fsr_pkg::*;
(
	// Configuration and faults
	input wire fsr_cfg_s cfg,
	input wire fsr_fault_s fault_active,
	input wire fsr_fault_s fault_mask,
	// Forced state requests
	output logic force_low,
	output logic force_high
);
	logic [FSR_NFAULT-1:0] want_low;
	logic [FSR_NFAULT-1:0] want_high;
	logic [FSR_NFAULT-1:0] live;
	logic [15:0] cfg_word;

	assign cfg_word = cfg;
	assign live = fault_active & ~fault_mask;

	genvar i;
	generate
		for (i = 0; i < FSR_NFAULT; i++) begin : g_src
			localparam int LSB = fsr_fault_lsb(i);
			// Reserved and no-action codes request nothing
			assign want_low[i] = live[i] && cfg_word[LSB+1:LSB] == FSR_ACT_LOW;
			assign want_high[i] = live[i] && cfg_word[LSB+1:LSB] == FSR_ACT_HIGH;
		end
	endgenerate

	// Pull-low is the safe state, so it wins over pull-high
	assign force_low = |want_low;
	assign force_high = ~(|want_low) & (|want_high);
endmodule
`default_nettype wire

/* File: verilog/fsr_clamp_timer.sv */
// Hold timer for the collector clamp
`timescale 1ns/1ps
`default_nettype none
module fsr_clamp_timer
	import fsr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Control
	input wire logic start,
	input wire logic [1:0] hold_code,
	// Status
	output logic active
);
	fsr_clamp_e state;
	logic [FSR_CLAMP_CNT_W-1:0] count;
	logic [FSR_CLAMP_CNT_W-1:0] load_value;

	// Hold is one 100 ns step per code value plus one
	assign load_value = FSR_CLAMP_CNT_W'(FSR_CLAMP_STEP_CYC * (int'(hold_code) + 1));

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state <= FSR_CLAMP_IDLE;
			count <= '0;
			active <= 1'b0;
		end else begin
			case (state)
				FSR_CLAMP_IDLE: begin
					if (start) begin
						state <= FSR_CLAMP_HOLD;
						count <= load_value - FSR_CLAMP_CNT_W'(1);
						active <= 1'b1;
					end
				end
				FSR_CLAMP_HOLD: begin
					// A new request restarts the hold
					if (start) begin
						count <= load_value - FSR_CLAMP_CNT_W'(1);
					end else if (count == '0) begin
						state <= FSR_CLAMP_IDLE;
						active <= 1'b0;
					end else begin
						count <= count - FSR_CLAMP_CNT_W'(1);
					end
				end
				default: begin
					state <= FSR_CLAMP_IDLE;
					active <= 1'b0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: verilog/fsr_top.sv */
// Fault output-state configuration and first analog input result registers
`timescale 1ns/1ps
`default_nettype none
module fsr_top
	import fsr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port from the serial interface
	input wire logic [3:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	output logic reg_addr_err,
	// Fault sources and their masks
	input wire fsr_fault_s fault_active,
	input wire fsr_fault_s fault_mask,
	// Normal gate control; PWM input feeds the time stamp
	input wire logic gate_drive_cmd,
	input wire logic pwm_positive_input,
	// Converter
	input wire logic adc_done,
	input wire logic [9:0] analog_one_code,
	// Clamp request
	input wire logic clamp_trigger,
	// Gate and clamp outputs
	output logic gate_pullup_output,
	output logic gate_pulldown_output,
	output logic collector_clamp,
	output logic fault_forced
);
	fsr_cfg_s cfg;
	fsr_result_s result;
	logic [5:0] stamp_count;
	logic pwm_prev;
	logic pwm_edge;
	logic force_low;
	logic force_high;
	logic clamp_active;
	logic next_pullup;
	logic next_pulldown;

	// Address decode shared by reads and writes
	function automatic logic fsr_addr_known(input logic [3:0] a);
		if (a == FSR_IDX_CFG) begin
			fsr_addr_known = 1'b1;
		end else if (a == FSR_IDX_RESULT) begin
			fsr_addr_known = 1'b1;
		end else begin
			fsr_addr_known = 1'b0;
		end
	endfunction

	// Configuration register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cfg <= FSR_CFG_RESET;
		end else if (reg_wr && reg_addr == FSR_IDX_CFG) begin
			cfg <= reg_wdata;
		end
	end

	// Read data; the result register ignores writes
	always_ff @(posedge clk) begin
		if (!rstn) begin
			reg_rdata <= 16'h0000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				if (reg_addr == FSR_IDX_CFG) begin
					reg_rdata <= cfg;
				end else if (reg_addr == FSR_IDX_RESULT) begin
					reg_rdata <= result;
				end else begin
					reg_rdata <= 16'h0000;
				end
			end
		end
	end

	// Unmapped access flag for one cycle
	always_ff @(posedge clk) begin
		if (!rstn) begin
			reg_addr_err <= 1'b0;
		end else begin
			reg_addr_err <= (reg_rd | reg_wr) & ~fsr_addr_known(reg_addr);
		end
	end

	// PWM input edge detection, both directions
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pwm_prev <= 1'b0;
		end else begin
			pwm_prev <= pwm_positive_input;
		end
	end

	assign pwm_edge = pwm_prev ^ pwm_positive_input;

	// Time-stamp counter; 6-bit width wraps 63 to 0
	always_ff @(posedge clk) begin
		if (!rstn) begin
			stamp_count <= FSR_STAMP_RESET;
		end else if (pwm_edge) begin
			stamp_count <= stamp_count + 6'h01;
		end
	end

	// Result register updates only on a completed conversion
	always_ff @(posedge clk) begin
		if (!rstn) begin
			result <= FSR_RESULT_RESET;
		end else if (adc_done) begin
			result.time_stamp <= stamp_count;
			result.analog_one_code <= analog_one_code;
		end
	end

	fsr_fault_action u_fault_action (
		.cfg(cfg),
		.fault_active(fault_active),
		.fault_mask(fault_mask),
		.force_low(force_low),
		.force_high(force_high)
	);

	fsr_clamp_timer u_clamp_timer (
		.clk(clk),
		.rstn(rstn),
		.start(clamp_trigger),
		.hold_code(cfg.collector_clamp_hold_time),
		.active(clamp_active)
	);

	// Gate output selection
	always_comb begin
		if (force_low) begin
			next_pullup = 1'b0;
			next_pulldown = 1'b1;
		end else if (force_high) begin
			next_pullup = 1'b1;
			next_pulldown = 1'b0;
		end else begin
			next_pullup = gate_drive_cmd;
			next_pulldown = ~gate_drive_cmd;
		end
	end

	// Gate outputs; pulldown is on from reset so the gate stays off
	always_ff @(posedge clk) begin
		if (!rstn) begin
			gate_pullup_output <= 1'b0;
			gate_pulldown_output <= 1'b1;
			fault_forced <= 1'b0;
		end else begin
			gate_pullup_output <= next_pullup;
			gate_pulldown_output <= next_pulldown;
			fault_forced <= force_low | force_high;
		end
	end

	// Clamp output
	always_ff @(posedge clk) begin
		if (!rstn) begin
			collector_clamp <= 1'b0;
		end else begin
			collector_clamp <= clamp_active;
		end
	end
endmodule
`default_nettype wire

/* File: verif/fsr_props.sv */
// Port assertions for the fault state and result register block
`timescale 1ns/1ps
`default_nettype none
module fsr_props
	import fsr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic reg_addr_err,
	// Faults and control
	input wire fsr_fault_s fault_active,
	input wire fsr_fault_s fault_mask,
	input wire logic gate_drive_cmd,
	input wire logic clamp_trigger,
	// Outputs
	input wire logic gate_pullup_output,
	input wire logic gate_pulldown_output,
	input wire logic collector_clamp,
	input wire logic fault_forced
);
	logic [15:0] cfg;
	logic [6:0] lo;
	logic [6:0] hi;

	// Shadow of the configuration word
	always_ff @(posedge clk) begin
		if (!rstn)
			cfg <= 16'h0000;
		else if (reg_wr && reg_addr == 4'h0)
			cfg <= reg_wdata;
	end

	always_comb begin
		for (int i = 0; i < 7; i++) begin
			lo[i] = fault_active[i] && !fault_mask[i] && cfg[(i == 6 ? 0 : 14 - 2 * i) +: 2] == 2'h0;
			hi[i] = fault_active[i] && !fault_mask[i] && cfg[(i == 6 ? 0 : 14 - 2 * i) +: 2] == 2'h1;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence trig_s;
		clamp_trigger ##2 1'b1;
	endsequence

	rd_latency_a: assert property (reg_rd |=> reg_rvalid)
		else $error("read valid missing");
	rv_spurious_a: assert property (!reg_rd |=> !reg_rvalid)
		else $error("read valid without read");
	unmapped_read_a: assert property (reg_rd && reg_addr > 4'h1 |=> reg_addr_err && reg_rdata == 16'h0000)
		else $error("unmapped read answer wrong");
	unmapped_write_a: assert property (reg_wr && reg_addr > 4'h1 |=> reg_addr_err)
		else $error("unmapped write not flagged");
	addr_err_idle_a: assert property (!reg_wr && !reg_rd |=> !reg_addr_err)
		else $error("address error without access");
	gate_apart_a: assert property (gate_pullup_output != gate_pulldown_output)
		else $error("gate pulled both ways or neither");
	force_low_a: assert property (|lo |=> fault_forced && gate_pulldown_output && !gate_pullup_output)
		else $error("gate not forced low");
	force_high_a: assert property (!(|lo) && |hi |=> fault_forced && gate_pullup_output && !gate_pulldown_output)
		else $error("gate not forced high");
	follow_cmd_a: assert property (!(|lo) && !(|hi) |=> !fault_forced && gate_pullup_output == $past(gate_drive_cmd) && gate_pulldown_output != $past(gate_drive_cmd))
		else $error("gate not following command");
	clamp_rise_a: assert property ($rose(collector_clamp) |-> $past(clamp_trigger, 2))
		else $error("clamp rose without trigger");
	clamp_hold_a: assert property (trig_s |-> collector_clamp [*8])
		else $error("clamp dropped early");
endmodule
bind fsr_top fsr_props u_props (.clk, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
	.reg_rvalid, .reg_addr_err, .fault_active, .fault_mask, .gate_drive_cmd, .clamp_trigger,
	.gate_pullup_output, .gate_pulldown_output, .collector_clamp, .fault_forced);
`default_nettype wire

/* File: verif/fsr_gate_model.sv */
// Power transistor gate seen through the pull-up and pull-down outputs
`timescale 1ns/1ps
`default_nettype none
module fsr_gate_model (
	// Drive
	input wire logic clk,
	input wire logic pull_up,
	input wire logic pull_down,
	// Gate level
	output logic gate_level
);
	logic last;
	// A floating gate drifts away from its last driven level
	always_ff @(posedge clk)
		if (pull_up ^ pull_down)
			last <= pull_up;
	assign gate_level = (pull_up && pull_down) ? 1'bx : pull_up ? 1'b1 : pull_down ? 1'b0 : ~last;
endmodule
`default_nettype wire

/* File: verif/fsr_top_bench.sv */
// Self-checking bench for the fault state and result register block
`timescale 1ns/1ps
`default_nettype none
module fsr_top_bench;
	import fsr_pkg::*;
	logic clk, rstn, reg_wr, reg_rd, reg_rvalid, reg_addr_err, gate_drive_cmd, pwm, adc_done;
	logic clamp_trigger, pu, pd, collector_clamp, fault_forced, gate_level, rd_err;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, d;
	logic [9:0] code;
	fsr_fault_s fault_active, fault_mask;
	int err_count, checks_done;

	fsr_top u_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.reg_addr_err(reg_addr_err), .fault_active(fault_active), .fault_mask(fault_mask),
		.gate_drive_cmd(gate_drive_cmd), .pwm_positive_input(pwm), .adc_done(adc_done),
		.analog_one_code(code), .clamp_trigger(clamp_trigger), .gate_pullup_output(pu),
		.gate_pulldown_output(pd), .collector_clamp(collector_clamp), .fault_forced(fault_forced));
	fsr_gate_model u_gate (.clk(clk), .pull_up(pu), .pull_down(pd), .gate_level(gate_level));

	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task wr(input logic [3:0] a, input logic [15:0] v);
		@(negedge clk);
		reg_addr = a; reg_wdata = v; reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	task rd(input logic [3:0] a);
		@(negedge clk);
		reg_addr = a; reg_rd = 1'b1;
		@(negedge clk);
		// Valid and error stand for one cycle after the taking edge
		chk("rvalid", 16'h0001, {15'h0, reg_rvalid});
		d = reg_rdata;
		rd_err = reg_addr_err;
		reg_rd = 1'b0;
	endtask

	task t_regs;
		rd(4'h0); chk("cfg reset", 16'h0000, d);
		rd(4'h1); chk("result reset", 16'h0000, d);
		wr(4'h0, 16'hbeef); rd(4'h0); chk("cfg", 16'hbeef, d);
		wr(4'h1, 16'h1234); rd(4'h1); chk("result ro", 16'h0000, d);
		rd(4'h9); chk("unmapped", 16'h0001, {15'h0, rd_err});
		wr(4'h9, 16'hffff); chk("unmapped wr", 16'h0001, {15'h0, reg_addr_err});
		rd(4'h0); chk("cfg kept", 16'hbeef, d);
		$display("register test done");
	endtask

	task t_faults;
		int l;
		for (int f = 0; f < 7; f++)
			for (int c = 0; c < 4; c++) begin
				l = f == 6 ? 0 : 14 - 2 * f;
				wr(4'h0, (16'hffff & ~(16'h3 << l)) | 16'(c << l));
				gate_drive_cmd = ~c[0];
				fault_active = fsr_fault_s'(7'h01 << f);
				repeat (2) @(negedge clk);
				chk("gate", {14'h0, c < 2, c < 2 ? c[0] : ~c[0]}, {14'h0, fault_forced, gate_level});
				fault_mask = fault_active;
				repeat (2) @(negedge clk);
				chk("masked", {14'h0, 1'b0, ~c[0]}, {14'h0, fault_forced, gate_level});
				fault_mask = 7'h00; fault_active = 7'h00;
			end
		$display("fault test done");
	endtask

	task t_clamp;
		int n;
		for (int c = 0; c < 4; c++) begin
			wr(4'h0, 16'hfff3 | 16'(c << 2));
			clamp_trigger = 1'b1;
			@(negedge clk);
			clamp_trigger = 1'b0;
			n = 0;
			repeat (100) @(negedge clk) n += collector_clamp;
			chk("clamp", 16'(20 * (c + 1)), 16'(n));
		end
		$display("clamp test done");
	endtask

	task t_stamp;
		repeat (65) @(negedge clk) pwm = ~pwm;
		@(negedge clk); adc_done = 1'b1; code = 10'h2a5;
		@(negedge clk); adc_done = 1'b0;
		repeat (3) @(negedge clk) pwm = ~pwm;
		rd(4'h1); chk("stamp wrap", {6'h01, 10'h2a5}, d);
		@(negedge clk); adc_done = 1'b1; code = 10'h155;
		@(negedge clk); adc_done = 1'b0;
		rd(4'h1); chk("stamp", {6'h04, 10'h155}, d);
		$display("stamp test done");
	endtask

	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		#100000;
		err_count++;
		report_and_stop;
	end

	initial begin
		{rstn, reg_wr, reg_rd, gate_drive_cmd, pwm, adc_done, clamp_trigger} = 7'h00;
		reg_addr = 4'h0; reg_wdata = 16'h0000; code = 10'h000;
		fault_active = 7'h00; fault_mask = 7'h00;
		err_count = 0; checks_done = 0;
		repeat (8) @(negedge clk);
		rstn = 1'b1;
		t_regs;
		t_faults;
		t_clamp;
		t_stamp;
		report_and_stop;
	end
endmodule
`default_nettype wire
